// File: core/diopr_top.sv
// Summary of operation
// - one eight-bit word in eight latches, shared by both ports.
// - ports independent; on simultaneous writes the user write wins.
// - master enable high idles the processor bus; user bus unaffected.
// - user strobe high, output enable low: drive stored word on user lines.
// - user strobe low: load user lines only while master clock high.
// - user strobe and output enable high: user lines released, no load.
// - enable, read and write commands all low: drive processor lines.
// - enable low, write, clock and user strobe high: store processor lines.
// - user strobe low blocks every processor write.
// - read high with write low, or enable high: processor port idle.
// - word written on one port reads inverted on the other.
// - word written on one port reads unchanged on the same port.
// - at start-up the user side reads ones, processor side zeros.
// - processor writes are also qualified by an internal status latch.
`timescale 1ns/10ps
module diopr_top (
    input wire logic clk_sys_in,              // 25 MHz system clock
    input wire logic rst_in,                  // sync reset, high
    input wire logic master_clock_in,         // latch strobe level
    input wire logic master_enable_n_in,      // processor port enable
    input wire logic read_command_n_in,       // processor read, low
    input wire logic write_command_in,        // processor write, high
    input wire logic user_input_strobe_n_in,  // user load, low
    input wire logic user_output_enable_n_in, // user drive, low
    input wire diopr_pkg::diopr_word_t user_data_lines_in,      // pin level
    output diopr_pkg::diopr_word_t user_data_lines_out,         // drive value
    output logic user_data_lines_oe_n_out,    // low while driving
    input wire diopr_pkg::diopr_word_t processor_data_lines_in, // pin level
    output diopr_pkg::diopr_word_t processor_data_lines_out,    // drive value
    output logic processor_data_lines_oe_n_out, // low while driving
    output logic [diopr_pkg::DIOPR_ST_WIDTH-1:0] status_out // status latch
);
    import diopr_pkg::*;

    // ----------------------------------------------------------------
    // port decoders
    // ----------------------------------------------------------------
    diopr_fn_e user_fn;
    diopr_fn_e proc_fn;
    diopr_req_s user_req;
    diopr_req_s proc_req;
    logic status_armed_q;
    logic status_armed_d;

    diopr_user_port u_user (
        .user_input_strobe_n_in(user_input_strobe_n_in),
        .user_output_enable_n_in(user_output_enable_n_in),
        .master_clock_in(master_clock_in),
        .data_in(user_data_lines_in),
        .fn_out(user_fn),
        .req_out(user_req)
    );

    diopr_proc_port u_proc (
        .master_enable_n_in(master_enable_n_in),
        .read_command_n_in(read_command_n_in),
        .write_command_in(write_command_in),
        .master_clock_in(master_clock_in),
        .user_input_strobe_n_in(user_input_strobe_n_in),
        .status_armed_in(status_armed_q),
        .data_in(processor_data_lines_in),
        .fn_out(proc_fn),
        .req_out(proc_req)
    );

    // ----------------------------------------------------------------
    // shared store
    // ----------------------------------------------------------------
    diopr_word_t store_q;
    diopr_word_t store_d;

    always_comb begin
        store_d = store_q;
        if (user_req.write) begin
            store_d = user_req.data;
        end else if (proc_req.write) begin
            store_d = proc_req.data;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            store_q <= DIOPR_STORE_RESET;
        end else begin
            store_q <= store_d;
        end
    end

    // ----------------------------------------------------------------
    // status latch
    // ----------------------------------------------------------------
    // armed out of reset; a user load that collides with a processor
    // write disarms processor writes until enable goes high or write drops, so a
    // stale processor write cannot land just after the user write ends
    logic [DIOPR_ST_WIDTH-1:0] status_q;
    logic [DIOPR_ST_WIDTH-1:0] status_d;
    logic proc_wants_wr;

    assign proc_wants_wr = !master_enable_n_in && write_command_in
        && master_clock_in;

    always_comb begin
        status_armed_d = status_armed_q;
        if (!user_input_strobe_n_in && proc_wants_wr) begin
            status_armed_d = 1'b0;
        end else if (master_enable_n_in || !write_command_in) begin
            status_armed_d = 1'b1;
        end
        status_d = status_q;
        status_d[DIOPR_ST_USER_WR] = user_req.write;
        status_d[DIOPR_ST_PROC_WR] = proc_req.write && !user_req.write;
        if (user_req.write && proc_wants_wr) begin
            status_d[DIOPR_ST_USER_WON] = 1'b1;
        end else if (proc_req.write && !user_req.write) begin
            status_d[DIOPR_ST_USER_WON] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            status_armed_q <= 1'b1;
            status_q <= '0;
        end else begin
            status_armed_q <= status_armed_d;
            status_q <= status_d;
        end
    end

    assign status_out = status_q;

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    // registered for clean pins; drive follows the controls by one cycle
    diopr_word_t user_out_q;
    diopr_word_t user_out_d;
    logic user_oe_n_q;
    logic user_oe_n_d;
    diopr_word_t proc_out_q;
    diopr_word_t proc_out_d;
    logic proc_oe_n_q;
    logic proc_oe_n_d;

    always_comb begin
        user_out_d = store_d;
        user_oe_n_d = !user_req.drive;
        proc_out_d = diopr_flip(store_d);
        proc_oe_n_d = !proc_req.drive;
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            user_out_q <= DIOPR_ALL_ONES;
            user_oe_n_q <= 1'b1;
            proc_out_q <= DIOPR_ALL_ZEROS;
            proc_oe_n_q <= 1'b1;
        end else begin
            user_out_q <= user_out_d;
            user_oe_n_q <= user_oe_n_d;
            proc_out_q <= proc_out_d;
            proc_oe_n_q <= proc_oe_n_d;
        end
    end

    assign user_data_lines_out = user_out_q;
    assign user_data_lines_oe_n_out = user_oe_n_q;
    assign processor_data_lines_out = proc_out_q;
    assign processor_data_lines_oe_n_out = proc_oe_n_q;

endmodule // diopr_top

// File: include/diopr_pkg.sv
package diopr_pkg;

    // ----------------------------------------------------------------
    // widths and reset values
    // ----------------------------------------------------------------
    localparam int unsigned DIOPR_WIDTH = 8;
    // all ones on the user side at start-up, hence all zeros at the processor
    localparam logic [7:0] DIOPR_STORE_RESET = 8'hFF;
    localparam logic [7:0] DIOPR_ALL_ONES = 8'hFF;
    localparam logic [7:0] DIOPR_ALL_ZEROS = 8'h00;

    // ----------------------------------------------------------------
    // bit positions of the status word
    // ----------------------------------------------------------------
    localparam int unsigned DIOPR_ST_USER_WON = 0;
    localparam int unsigned DIOPR_ST_PROC_WR = 1;
    localparam int unsigned DIOPR_ST_USER_WR = 2;
    localparam int unsigned DIOPR_ST_WIDTH = 3;

    // ----------------------------------------------------------------
    // port functions, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DIOPR_FN_IDLE = 3'h1,
        DIOPR_FN_OUT = 3'h2,
        DIOPR_FN_IN = 3'h4
    } diopr_fn_e;

    typedef logic [7:0] diopr_word_t;

    // decoded request of one port toward the shared store
    typedef struct packed {
        logic drive;
        logic write;
        diopr_word_t data;
    } diopr_req_s;

    // the processor side sees the stored word bitwise inverted
    function automatic diopr_word_t diopr_flip(input diopr_word_t w);
        diopr_flip = ~w;
    endfunction

endpackage

// File: core/diopr_user_port.sv
`timescale 1ns/10ps
module diopr_user_port (
    input wire logic user_input_strobe_n_in,  // low: load from user lines
    input wire logic user_output_enable_n_in, // low: drive user lines
    input wire logic master_clock_in,         // latch strobe level
    input wire diopr_pkg::diopr_word_t data_in, // user lines as seen
    output diopr_pkg::diopr_fn_e fn_out,      // decoded function
    output diopr_pkg::diopr_req_s req_out     // request to the store
);
    import diopr_pkg::*;

    // ----------------------------------------------------------------
    // function decode
    // ----------------------------------------------------------------
    always_comb begin
        if (!user_input_strobe_n_in) begin
            fn_out = DIOPR_FN_IN;
        end else if (!user_output_enable_n_in) begin
            fn_out = DIOPR_FN_OUT;
        end else begin
            fn_out = DIOPR_FN_IDLE;
        end
    end

    always_comb begin
        req_out.data = data_in;
        case (fn_out)
            DIOPR_FN_IN: begin
                req_out.drive = 1'b0;
                req_out.write = master_clock_in;
            end
            DIOPR_FN_OUT: begin
                req_out.drive = 1'b1;
                req_out.write = 1'b0;
            end
            DIOPR_FN_IDLE: begin
                req_out.drive = 1'b0;
                req_out.write = 1'b0;
            end
            default: begin
                req_out.drive = 1'b0;
                req_out.write = 1'b0;
            end
        endcase
    end

endmodule // diopr_user_port

// File: core/diopr_proc_port.sv
`timescale 1ns/10ps
module diopr_proc_port (
    input wire logic master_enable_n_in,  // low: processor port enabled
    input wire logic read_command_n_in,   // low: drive processor lines
    input wire logic write_command_in,    // high: store processor lines
    input wire logic master_clock_in,     // latch strobe level
    input wire logic user_input_strobe_n_in, // low: user owns the store
    input wire logic status_armed_in,     // internal status latch
    input wire diopr_pkg::diopr_word_t data_in, // processor lines as seen
    output diopr_pkg::diopr_fn_e fn_out,  // decoded function
    output diopr_pkg::diopr_req_s req_out // request to the store
);
    import diopr_pkg::*;

    // ----------------------------------------------------------------
    // function decode
    // ----------------------------------------------------------------
    always_comb begin
        fn_out = DIOPR_FN_IDLE;
        if (master_enable_n_in) begin
            fn_out = DIOPR_FN_IDLE;
        end else if (!read_command_n_in && !write_command_in) begin
            fn_out = DIOPR_FN_OUT;
        end else if (write_command_in && user_input_strobe_n_in
            && status_armed_in) begin
            // only writes wait on the status latch; reads never stall
            fn_out = DIOPR_FN_IN;
        end
    end

    always_comb begin
        // stored in user polarity so each port reads back its own value
        req_out.data = diopr_flip(data_in);
        case (fn_out)
            DIOPR_FN_OUT: begin
                req_out.drive = 1'b1;
                req_out.write = 1'b0;
            end
            DIOPR_FN_IN: begin
                req_out.drive = 1'b0;
                req_out.write = master_clock_in;
            end
            DIOPR_FN_IDLE: begin
                req_out.drive = 1'b0;
                req_out.write = 1'b0;
            end
            default: begin
                req_out.drive = 1'b0;
                req_out.write = 1'b0;
            end
        endcase
    end

endmodule // diopr_proc_port

// File: sim/diopr_top_assertions.sv
`timescale 1ns/10ps
module diopr_top_checker (
    input wire logic clk_sys_in, // clock
    input wire logic rst_in, // reset
    input wire logic master_clock_in, // latch strobe
    input wire logic master_enable_n_in, // port enable
    input wire logic read_command_n_in, // read
    input wire logic write_command_in, // write
    input wire logic user_input_strobe_n_in, // user load
    input wire logic user_output_enable_n_in, // user drive
    input wire diopr_pkg::diopr_word_t user_data_lines_in, // user level
    input wire diopr_pkg::diopr_word_t user_data_lines_out, // user value
    input wire logic user_data_lines_oe_n_out, // user enable
    input wire diopr_pkg::diopr_word_t processor_data_lines_in, // level
    input wire diopr_pkg::diopr_word_t processor_data_lines_out, // value
    input wire logic processor_data_lines_oe_n_out, // proc enable
    input wire logic [diopr_pkg::DIOPR_ST_WIDTH-1:0] status_out // status
);
    import diopr_pkg::*;
    logic armed_q;
    logic armed_d;
    logic pwant;
    assign pwant = !master_enable_n_in && write_command_in && master_clock_in;
    // mirror of the hidden latch, so a refused write can be told apart
    always_comb begin
        armed_d = armed_q;
        if (rst_in || master_enable_n_in || !write_command_in) begin
            armed_d = 1'b1;
        end else if (pwant && !user_input_strobe_n_in) begin
            armed_d = 1'b0;
        end
    end
    always_ff @(posedge clk_sys_in) begin
        armed_q <= armed_d;
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence s_user_wr;
        !user_input_strobe_n_in && master_clock_in;
    endsequence
    sequence s_proc_wr;
        pwant && user_input_strobe_n_in && armed_q;
    endsequence
    property p_user_wr;
        s_user_wr |=> user_data_lines_out == $past(user_data_lines_in)
            && status_out[DIOPR_ST_USER_WR];
    endproperty
    a_user_wr: assert property (p_user_wr)
        else $error("user write lost");
    property p_proc_wr;
        s_proc_wr |=> processor_data_lines_out
            == $past(processor_data_lines_in);
    endproperty
    a_proc_wr: assert property (p_proc_wr)
        else $error("processor write lost");
    property p_collide;
        pwant && !user_input_strobe_n_in |=> !status_out[DIOPR_ST_PROC_WR]
            && status_out[DIOPR_ST_USER_WON];
    endproperty
    a_collide: assert property (p_collide)
        else $error("user did not win");
    property p_refuse;
        pwant && user_input_strobe_n_in && !armed_q
            |=> $stable(user_data_lines_out);
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("disarmed write stored");
    property p_idle;
        !master_clock_in || (master_enable_n_in && user_input_strobe_n_in)
            |=> $stable(user_data_lines_out);
    endproperty
    a_idle: assert property (p_idle)
        else $error("word changed without write");
    property p_cross;
        user_data_lines_out == ~processor_data_lines_out;
    endproperty
    a_cross: assert property (p_cross)
        else $error("ports not inverse");
    property p_drive;
        1'b1 |=> user_data_lines_oe_n_out
            != $past(user_input_strobe_n_in && !user_output_enable_n_in)
            && processor_data_lines_oe_n_out != $past(!master_enable_n_in
            && !read_command_n_in && !write_command_in);
    endproperty
    a_drive: assert property (p_drive)
        else $error("drive enable wrong");
    property p_reset;
        disable iff (1'b0) rst_in |=> user_data_lines_out == DIOPR_ALL_ONES
            && processor_data_lines_out == DIOPR_ALL_ZEROS
            && user_data_lines_oe_n_out && processor_data_lines_oe_n_out;
    endproperty
    a_reset: assert property (p_reset)
        else $error("start state wrong");
endmodule // diopr_top_checker
bind diopr_top diopr_top_checker u_chk (.*);

// File: sim/diopr_far_model.sv
`timescale 1ns/10ps
module diopr_far_model (
    input wire logic clk_sys_in, // clock
    input wire logic usr_en_in, // user equipment drives
    input wire diopr_pkg::diopr_word_t usr_in, // its value
    input wire logic prc_en_in, // processor drives
    input wire diopr_pkg::diopr_word_t prc_in, // its value
    input wire logic dut_u_oe_n_in, // device drives user lines
    input wire diopr_pkg::diopr_word_t dut_u_in, // device user value
    input wire logic dut_p_oe_n_in, // device drives processor lines
    input wire diopr_pkg::diopr_word_t dut_p_in, // device processor value
    output diopr_pkg::diopr_word_t u_lvl_out, // user wire level
    output diopr_pkg::diopr_word_t p_lvl_out // processor wire level
);
    import diopr_pkg::*;
    diopr_word_t u_last = 8'h00;
    diopr_word_t p_last = 8'h00;
    // a released bus floats: show the inverse of its last level
    assign u_lvl_out = usr_en_in ? usr_in : !dut_u_oe_n_in ? dut_u_in : ~u_last;
    assign p_lvl_out = prc_en_in ? prc_in : !dut_p_oe_n_in ? dut_p_in : ~p_last;
    always @(posedge clk_sys_in) begin
        u_last <= u_lvl_out;
        p_last <= p_lvl_out;
    end
endmodule // diopr_far_model

// File: sim/testbench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module testbench;
    import diopr_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic master_clock_in = 1'b0;
    logic master_enable_n_in = 1'b1;
    logic read_command_n_in = 1'b1;
    logic write_command_in = 1'b0;
    logic user_input_strobe_n_in = 1'b1;
    logic user_output_enable_n_in = 1'b1;
    diopr_word_t user_data_lines_in, user_data_lines_out, st;
    diopr_word_t processor_data_lines_in, processor_data_lines_out;
    diopr_word_t ud = 8'h00;
    diopr_word_t pd = 8'h00;
    logic user_data_lines_oe_n_out, processor_data_lines_oe_n_out;
    logic [DIOPR_ST_WIDTH-1:0] status_out, e_st;
    logic armed, e_uoe, e_poe;
    logic live = 1'b0;
    int err_count = 0;
    int checked = 0;
    // {mclk, enable_n, read_n, write, strobe_n, output_enable_n}
    logic [5:0] corner [11] = '{6'b111001, 6'b101111, 6'b101101,
        6'b101111, 6'b001111, 6'b000010, 6'b101111, 6'b111111,
        6'b100010, 6'b110000, 6'b011000};

    always #20 clk_sys_in = ~clk_sys_in;
    diopr_top u_dut (.*);
    diopr_far_model u_far (.clk_sys_in(clk_sys_in),
        .usr_en_in(!user_input_strobe_n_in), .usr_in(ud),
        .prc_en_in(!master_enable_n_in && write_command_in), .prc_in(pd),
        .dut_u_oe_n_in(user_data_lines_oe_n_out),
        .dut_u_in(user_data_lines_out),
        .dut_p_oe_n_in(processor_data_lines_oe_n_out),
        .dut_p_in(processor_data_lines_out),
        .u_lvl_out(user_data_lines_in), .p_lvl_out(processor_data_lines_in));

    function automatic diopr_word_t f_store(input logic uw, pw,
        input diopr_word_t s, u, p);
        f_store = uw ? u : pw ? ~p : s;
    endfunction

    always @(posedge clk_sys_in) begin : ref_model
        logic uw, pr, pw;
        uw = !user_input_strobe_n_in && master_clock_in;
        pr = !master_enable_n_in && write_command_in && master_clock_in;
        pw = pr && user_input_strobe_n_in && armed;
        if (rst_in) begin
            st = DIOPR_STORE_RESET;
            armed = 1'b1;
            e_st = '0;
        end else begin
            st = f_store(uw, pw, st, user_data_lines_in,
                processor_data_lines_in);
            e_st = {uw, pw, (uw && pr) || (e_st[0] && !pw)};
            armed = master_enable_n_in || !write_command_in
                || (armed && !(pr && !user_input_strobe_n_in));
        end
        e_uoe = rst_in || !(user_input_strobe_n_in
            && !user_output_enable_n_in);
        e_poe = rst_in || !(!master_enable_n_in && !read_command_n_in
            && !write_command_in);
        live <= 1'b1;
    end

    always @(negedge clk_sys_in) begin
        if (live) begin
            `CHK("user_out", st, user_data_lines_out)
            `CHK("proc_out", ~st, processor_data_lines_out)
            `CHK("user_oe_n", e_uoe, user_data_lines_oe_n_out)
            `CHK("proc_oe_n", e_poe, processor_data_lines_oe_n_out)
            `CHK("status", e_st, status_out)
        end
    end

    task automatic step(input logic [5:0] c);
        @(posedge clk_sys_in);
        {master_clock_in, master_enable_n_in, read_command_n_in,
            write_command_in, user_input_strobe_n_in,
            user_output_enable_n_in} <= c;
        ud <= 8'($urandom);
        pd <= 8'($urandom);
    endtask

    task automatic end_of_test();
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(86886));
        repeat (10) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        foreach (corner[i]) step(corner[i]);
        repeat (2000) step(6'($urandom));
        rst_in <= 1'b1;
        repeat (3) step(6'($urandom));
        rst_in <= 1'b0;
        repeat (500) step(6'($urandom));
        step(6'b011111);
        @(negedge clk_sys_in);
        @(posedge clk_sys_in);
        end_of_test();
    end

    initial begin
        #(40 * 3000);
        err_count++;
        end_of_test();
    end
endmodule // testbench
